// [hdl/swr_pkg.sv]
// shared constants for the single-wire rom function layer: commands, states, slot timing
// assumes a 100 MHz clock on both ends and a cycle-level abstraction of the slot waveform
package swr_pkg;
  localparam logic [7:0] CMD_READ = 8'h33;
  localparam logic [7:0] CMD_MATCH = 8'h55;
  localparam logic [7:0] CMD_SEARCH = 8'hF0;
  localparam logic [7:0] CMD_SKIP = 8'hCC;
  localparam logic [7:0] CMD_RESUME = 8'hA5;
  localparam logic [7:0] CMD_OD_SKIP = 8'h3C;
  localparam logic [7:0] CMD_OD_MATCH = 8'h69;
  localparam logic [7:0] CRC_POLY_REV = 8'h8C; // x^8+x^5+x^4+1, bit-reversed
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [2:0] CMD_LAST = 3'h7;
  localparam logic [5:0] ID_LAST = 6'h3F;

  // timing: printed figures, then derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int RST_LONG_US = 480;
  localparam int OD_KEEP_US = 80;
  localparam logic [15:0] RST_LONG_CYC = 16'(RST_LONG_US * CLK_MHZ);
  localparam logic [15:0] OD_KEEP_CYC = 16'(OD_KEEP_US * CLK_MHZ);

  // slot abstraction, in clock cycles
  localparam logic [3:0] SLOT_LAST = 4'hB;
  localparam logic [3:0] W0_END = 4'h6;
  localparam logic [3:0] CTL_SAMPLE = 4'h5;
  localparam logic [3:0] CTL_FIRST = 4'h0;
  localparam logic [3:0] CTL_REL1 = 4'h1;
  localparam logic [3:0] RSTH_LAST = 4'hF;
  localparam logic [2:0] DEV_SAMPLE = 3'h3;
  localparam logic [2:0] DEV_HOLD = 3'h6;
  localparam logic [15:0] RST_MIN_CYC = 16'h0010;
  localparam logic [3:0] PDH_CYC = 4'h2;
  localparam logic [3:0] PDL_END = 4'hA;

  localparam logic [1:0] OP_RESET = 2'h0;
  localparam logic [1:0] OP_ROM = 2'h1;

  typedef enum logic [2:0] {
    DS_HALT = 3'b000, DS_PRES = 3'b001, DS_CMD = 3'b011, DS_MATCH = 3'b010,
    DS_SRCH = 3'b110, DS_TXID = 3'b111, DS_FUNC = 3'b101
  } swr_dev_state_t;

  typedef enum logic [2:0] {
    CS_IDLE = 3'b000, CS_RLOW = 3'b001, CS_RWAIT = 3'b011, CS_CMD = 3'b010,
    CS_WRID = 3'b110, CS_RDID = 3'b111, CS_SRCH = 3'b101, CS_DONE = 3'b100
  } swr_ctl_state_t;

  // one lsb-first step of the identity crc
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic b);
    logic fb;
    fb = crc[0] ^ b;
    crc8_step = (crc >> 1) ^ (fb ? CRC_POLY_REV : CRC_INIT);
  endfunction

  // crc over family code and serial number, family lsb first
  function automatic logic [7:0] crc8_56(input logic [55:0] d);
    logic [7:0] c;
    c = CRC_INIT;
    for (int i = 0; i < 56; i++)
    begin
      c = crc8_step(c, d[i]);
    end
    crc8_56 = c;
  endfunction
endpackage

// [hdl/swr_if.sv]
// the one open-drain line between a controller and a peripheral
// assumes one pull-up: the line is high unless some end drives it low
`timescale 1ns/1ns
interface swr_if;
  logic ctl_o;
  logic ctl_oe_n;
  logic dev_o;
  logic dev_oe_n;
  logic line;

  // wired-and of every enabled driver
  assign line = !((!ctl_oe_n && !ctl_o) || (!dev_oe_n && !dev_o));

  modport ctl (input line, output ctl_o, output ctl_oe_n);
  modport dev (input line, output dev_o, output dev_oe_n);
endinterface

// [hdl/swr_dev.sv]
// peripheral end: reset/presence, rom function decode, identity, resume and speed flags
// assumes the line is sampled synchronously and slots follow the cycle model in swr_pkg
`timescale 1ns/1ns
module swr_dev #(
  parameter logic [7:0] FAMILY_CODE = 8'h5A, // arbitrary value
  parameter logic [47:0] SERIAL_NUM = 48'h0000_1234_5678, // arbitrary value
  parameter logic [15:0] OD_KEEP_CYC = swr_pkg::OD_KEEP_CYC
)(
  input wire logic clk,
  input wire logic srst,
  swr_if.dev link,
  output logic selected,
  output logic [7:0] rom_cmd,
  output logic resume_select_flag,
  output logic fast_speed_flag,
  output logic bus_reset
);
  // identity is fixed at elaboration
  localparam logic [63:0] ID = {swr_pkg::crc8_56({SERIAL_NUM, FAMILY_CODE}),
    SERIAL_NUM, FAMILY_CODE};

  swr_pkg::swr_dev_state_t state_r;
  logic line_q_r;
  logic [15:0] low_cnt_r;
  logic [2:0] dc_r;
  logic [3:0] pc_r;
  logic oe_n_r;
  logic [5:0] idx_r;
  logic [1:0] phase_r;
  logic [7:0] cmd_r;
  logic match_r;
  logic rc_r;
  logic od_r;
  logic od_prior_r;
  logic [7:0] rom_cmd_r;
  logic sel_r;
  logic bus_reset_r;

  logic line_i;
  logic rst_seen;
  logic fall;
  logic slot_on;
  logic tx_zero;
  logic bit_take;
  logic [7:0] cmd_byte;
  logic cmd_done;
  logic id_bit;
  logic match_ok;
  logic match_end;
  logic srch_fail;
  logic srch_end;

  assign line_i = link.line;
  assign link.dev_o = 1'b0; // open drain: only ever pulls low
  assign link.dev_oe_n = oe_n_r;
  assign selected = sel_r;
  assign rom_cmd = rom_cmd_r;
  assign resume_select_flag = rc_r;
  assign fast_speed_flag = od_r;
  assign bus_reset = bus_reset_r;

  // event decode shared by the processes below
  assign rst_seen = line_i && !line_q_r && (low_cnt_r >= swr_pkg::RST_MIN_CYC);
  assign fall = !line_i && line_q_r;
  assign slot_on = (state_r == swr_pkg::DS_CMD) || (state_r == swr_pkg::DS_TXID) ||
    (state_r == swr_pkg::DS_MATCH) || (state_r == swr_pkg::DS_SRCH);
  assign bit_take = (dc_r == swr_pkg::DEV_SAMPLE);
  assign id_bit = ID[idx_r];
  assign cmd_byte = {line_i, cmd_r[7:1]};
  assign cmd_done = (state_r == swr_pkg::DS_CMD) && bit_take &&
    (idx_r[2:0] == swr_pkg::CMD_LAST);
  assign match_ok = match_r && (line_i == id_bit);
  assign match_end = (state_r == swr_pkg::DS_MATCH) && bit_take && (idx_r == swr_pkg::ID_LAST);
  assign srch_fail = (state_r == swr_pkg::DS_SRCH) && bit_take && (phase_r == 2'h2) &&
    (line_i != id_bit);
  assign srch_end = (state_r == swr_pkg::DS_SRCH) && bit_take && (phase_r == 2'h2) &&
    (line_i == id_bit) && (idx_r == swr_pkg::ID_LAST);

  // which bit the device puts on the line in this slot; a one means stay released
  always_comb
  begin
    tx_zero = 1'b0;
    if (state_r == swr_pkg::DS_TXID)
    begin
      tx_zero = !id_bit;
    end
    else if (state_r == swr_pkg::DS_SRCH)
    begin
      tx_zero = (phase_r == 2'h0) ? !id_bit : ((phase_r == 2'h1) ? id_bit : 1'b0);
    end
  end

  // line history and low-time measure; saturates so a stuck-low line stays a reset
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      line_q_r <= 1'b1;
      low_cnt_r <= 16'h0000;
    end
    else
    begin
      line_q_r <= line_i;
      if (line_i)
        low_cnt_r <= 16'h0000;
      else if (low_cnt_r != 16'hFFFF)
        low_cnt_r <= low_cnt_r + 16'h0001;
    end
  end

  // slot timer started by the controller's falling edge
  always_ff @(posedge clk)
  begin
    if (srst || rst_seen)
      dc_r <= 3'h0;
    else if (dc_r == 3'h0 && fall && slot_on)
      dc_r <= 3'h1;
    else if (dc_r == swr_pkg::DEV_HOLD)
      dc_r <= 3'h0;
    else if (dc_r != 3'h0)
      dc_r <= dc_r + 3'h1;
  end

  // presence timer after a reset pulse
  always_ff @(posedge clk)
  begin
    if (srst || rst_seen)
      pc_r <= 4'h0;
    else if (state_r == swr_pkg::DS_PRES)
      pc_r <= pc_r + 4'h1;
  end

  // pull-down: presence pulse and zero bits; released on any bus reset
  always_ff @(posedge clk)
  begin
    if (srst || rst_seen)
      oe_n_r <= 1'b1;
    else if (state_r == swr_pkg::DS_PRES && pc_r == swr_pkg::PDH_CYC)
      oe_n_r <= 1'b0;
    else if (state_r == swr_pkg::DS_PRES && pc_r == swr_pkg::PDL_END)
      oe_n_r <= 1'b1;
    else if (dc_r == 3'h0 && fall && slot_on && tx_zero)
      oe_n_r <= 1'b0;
    else if (dc_r == swr_pkg::DEV_HOLD)
      oe_n_r <= 1'b1;
  end

  // rom function sequencer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= swr_pkg::DS_HALT;
      idx_r <= 6'h00;
      phase_r <= 2'h0;
      cmd_r <= 8'h00;
      match_r <= 1'b0;
    end
    else if (rst_seen)
    begin
      state_r <= swr_pkg::DS_PRES;
      idx_r <= 6'h00;
      phase_r <= 2'h0;
    end
    else
    begin
      unique case (state_r)
        swr_pkg::DS_HALT, swr_pkg::DS_FUNC:
        begin
          idx_r <= 6'h00; // only a bus reset leaves
        end
        swr_pkg::DS_PRES:
        begin
          if (pc_r == swr_pkg::PDL_END)
            state_r <= swr_pkg::DS_CMD;
        end
        swr_pkg::DS_CMD:
        begin
          if (bit_take)
          begin
            cmd_r <= cmd_byte;
            idx_r <= cmd_done ? 6'h00 : idx_r + 6'h01;
            match_r <= 1'b1;
          end
          if (cmd_done)
          begin
            unique case (cmd_byte)
              swr_pkg::CMD_READ: state_r <= swr_pkg::DS_TXID;
              swr_pkg::CMD_MATCH, swr_pkg::CMD_OD_MATCH: state_r <= swr_pkg::DS_MATCH;
              swr_pkg::CMD_SEARCH: state_r <= swr_pkg::DS_SRCH;
              swr_pkg::CMD_SKIP, swr_pkg::CMD_OD_SKIP: state_r <= swr_pkg::DS_FUNC;
              swr_pkg::CMD_RESUME:
                state_r <= rc_r ? swr_pkg::DS_FUNC : swr_pkg::DS_HALT;
              default: state_r <= swr_pkg::DS_HALT;
            endcase
          end
        end
        swr_pkg::DS_TXID:
        begin
          if (bit_take)
          begin
            idx_r <= idx_r + 6'h01;
            if (idx_r == swr_pkg::ID_LAST)
              state_r <= swr_pkg::DS_FUNC;
          end
        end
        swr_pkg::DS_MATCH:
        begin
          if (bit_take)
          begin
            match_r <= match_ok;
            idx_r <= idx_r + 6'h01;
          end
          if (match_end)
            state_r <= match_ok ? swr_pkg::DS_FUNC : swr_pkg::DS_HALT;
        end
        swr_pkg::DS_SRCH:
        begin
          if (srch_fail)
            state_r <= swr_pkg::DS_HALT;
          else if (srch_end)
            state_r <= swr_pkg::DS_FUNC;
          else if (bit_take)
          begin
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
            if (phase_r == 2'h2)
              idx_r <= idx_r + 6'h01;
          end
        end
      endcase
    end
  end

  // resume flag: survives bus resets, follows the outcome of the last match or search; read, skip and resume leave it
  always_ff @(posedge clk)
  begin
    if (srst)
      rc_r <= 1'b0;
    else if ((match_end && match_ok) || srch_end)
      rc_r <= 1'b1;
    else if ((match_end && !match_ok) || srch_fail)
      rc_r <= 1'b0;
  end

  // speed flag; a 80..480 us reset is undefined speed, this design drops to standard
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      od_r <= 1'b0;
      od_prior_r <= 1'b0;
    end
    else if (rst_seen)
    begin
      if (low_cnt_r > OD_KEEP_CYC)
        od_r <= 1'b0;
    end
    else if (cmd_done)
    begin
      od_prior_r <= od_r;
      if (cmd_byte == swr_pkg::CMD_OD_SKIP || cmd_byte == swr_pkg::CMD_OD_MATCH)
        od_r <= 1'b1;
    end
    else if (match_end && !match_ok && rom_cmd_r == swr_pkg::CMD_OD_MATCH && !od_prior_r)
      od_r <= 1'b0;
  end

  // user-side status
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rom_cmd_r <= 8'h00;
      sel_r <= 1'b0;
      bus_reset_r <= 1'b0;
    end
    else
    begin
      bus_reset_r <= rst_seen;
      sel_r <= (state_r == swr_pkg::DS_FUNC) && !rst_seen;
      if (cmd_done)
        rom_cmd_r <= cmd_byte;
    end
  end
endmodule

// [hdl/swr_ctl.sv]
// controller end: reset pulses, rom command bytes, identity write, read and search
// assumes one request at a time from the user side and the slot model in swr_pkg
`timescale 1ns/1ns
module swr_ctl #(
  parameter logic [15:0] RST_LONG_CYC = swr_pkg::RST_LONG_CYC,
  parameter logic [15:0] OD_RST_CYC = swr_pkg::OD_KEEP_CYC
)(
  input wire logic clk,
  input wire logic srst,
  swr_if.ctl link,
  input wire logic req_valid,
  input wire logic [1:0] req_op,
  input wire logic req_fast_reset,
  input wire logic [7:0] req_cmd,
  input wire logic [63:0] req_id,
  output logic req_ready,
  output logic rsp_done,
  output logic rsp_presence,
  output logic [63:0] rsp_id,
  output logic rsp_crc_ok,
  output logic rsp_err,
  output logic fast_speed_flag
);
  swr_pkg::swr_ctl_state_t state_r;
  logic [3:0] cc_r;
  logic [15:0] rl_r;
  logic [15:0] rst_len_r;
  logic oe_n_r;
  logic [5:0] idx_r;
  logic [1:0] phase_r;
  logic rb_r;
  logic rd0_r;
  logic dir_r;
  logic [7:0] cmd_r;
  logic [63:0] want_r;
  logic [63:0] id_r;
  logic [7:0] crc_r;
  logic pres_r;
  logic err_r;
  logic crc_ok_r;
  logic od_r;
  logic done_r;
  logic ready_r;
  logic slot_st;
  logic wbit;
  logic slot_end;
  logic [7:0] crc_nxt;
  logic go;

  assign link.ctl_o = 1'b0;
  assign link.ctl_oe_n = oe_n_r; // released whenever idle
  assign req_ready = ready_r;
  assign rsp_done = done_r;
  assign rsp_presence = pres_r;
  assign rsp_id = id_r;
  assign rsp_crc_ok = crc_ok_r;
  assign rsp_err = err_r;
  assign fast_speed_flag = od_r;

  assign go = req_valid && (state_r == swr_pkg::CS_IDLE);
  assign slot_st = (state_r == swr_pkg::CS_CMD) || (state_r == swr_pkg::CS_WRID) ||
    (state_r == swr_pkg::CS_RDID) || (state_r == swr_pkg::CS_SRCH);
  assign slot_end = slot_st && (cc_r == swr_pkg::SLOT_LAST);
  assign crc_nxt = swr_pkg::crc8_step(crc_r, (state_r == swr_pkg::CS_SRCH) ? dir_r : rb_r);

  // bit put on the line this slot; reads and search reads are write-one slots
  always_comb
  begin
    wbit = 1'b1;
    if (state_r == swr_pkg::CS_CMD)
      wbit = cmd_r[idx_r[2:0]];
    else if (state_r == swr_pkg::CS_WRID)
      wbit = want_r[idx_r];
    else if (state_r == swr_pkg::CS_SRCH && phase_r == 2'h2)
      wbit = dir_r;
  end

  // ready kept in a flop so the user side sees no decode glitch; tracks the idle state
  always_ff @(posedge clk)
  begin
    if (srst)
      ready_r <= 1'b1;
    else if (go)
      ready_r <= 1'b0;
    else if (state_r == swr_pkg::CS_DONE)
      ready_r <= 1'b1; // done always hands back to idle
  end

  // line driver: reset low time, then slot lows
  always_ff @(posedge clk)
  begin
    if (srst)
      oe_n_r <= 1'b1;
    else if (go && req_op == swr_pkg::OP_RESET)
      oe_n_r <= 1'b0;
    else if (state_r == swr_pkg::CS_RLOW && rl_r == rst_len_r)
      oe_n_r <= 1'b1;
    else if (slot_st && cc_r == swr_pkg::CTL_FIRST)
      oe_n_r <= 1'b0;
    else if (slot_st && ((cc_r == swr_pkg::CTL_REL1 && wbit) || cc_r == swr_pkg::W0_END))
      oe_n_r <= 1'b1;
  end

  // slot cycle counter and line sample
  always_ff @(posedge clk)
  begin
    if (srst || !slot_st)
    begin
      cc_r <= 4'h0;
      rb_r <= 1'b1;
    end
    else
    begin
      cc_r <= slot_end ? 4'h0 : cc_r + 4'h1;
      if (cc_r == swr_pkg::CTL_SAMPLE)
        rb_r <= link.line;
    end
  end

  // speed: follows the same overdrive commands as the peripherals
  always_ff @(posedge clk)
  begin
    if (srst)
      od_r <= 1'b0;
    else if (go && req_op == swr_pkg::OP_RESET && !(req_fast_reset && od_r))
      od_r <= 1'b0;
    else if (state_r == swr_pkg::CS_CMD && slot_end && idx_r[2:0] == swr_pkg::CMD_LAST &&
      (cmd_r == swr_pkg::CMD_OD_SKIP || cmd_r == swr_pkg::CMD_OD_MATCH))
      od_r <= 1'b1;
  end

  // transaction sequencer
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state_r <= swr_pkg::CS_IDLE;
      rl_r <= 16'h0000;
      rst_len_r <= 16'h0000;
      idx_r <= 6'h00;
      phase_r <= 2'h0;
      rd0_r <= 1'b0;
      dir_r <= 1'b0;
      cmd_r <= 8'h00;
      want_r <= 64'h0000_0000_0000_0000;
      id_r <= 64'h0000_0000_0000_0000;
      crc_r <= swr_pkg::CRC_INIT;
      pres_r <= 1'b0;
      err_r <= 1'b0;
      crc_ok_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= (state_r == swr_pkg::CS_DONE);
      unique case (state_r)
        swr_pkg::CS_IDLE:
        begin
          idx_r <= 6'h00;
          phase_r <= 2'h0;
          rl_r <= 16'h0000;
          if (go)
          begin
            cmd_r <= req_cmd;
            want_r <= req_id;
            err_r <= 1'b0;
            crc_r <= swr_pkg::CRC_INIT;
            // a fast reset keeps overdrive so the bus can be re-addressed
            rst_len_r <= (req_fast_reset && od_r) ? OD_RST_CYC - 16'h0001 :
              RST_LONG_CYC - 16'h0001;
            if (req_op == swr_pkg::OP_RESET)
            begin
              state_r <= swr_pkg::CS_RLOW;
              pres_r <= 1'b0;
            end
            else
              state_r <= swr_pkg::CS_CMD;
          end
        end
        swr_pkg::CS_RLOW:
        begin
          rl_r <= rl_r + 16'h0001;
          if (rl_r == rst_len_r)
          begin
            state_r <= swr_pkg::CS_RWAIT;
            rl_r <= 16'h0000;
          end
        end
        swr_pkg::CS_RWAIT:
        begin
          rl_r <= rl_r + 16'h0001;
          if (rl_r != 16'h0000 && !link.line)
            pres_r <= 1'b1;
          if (rl_r[3:0] == swr_pkg::RSTH_LAST)
            state_r <= swr_pkg::CS_DONE;
        end
        swr_pkg::CS_CMD:
        begin
          if (slot_end)
          begin
            idx_r <= 6'h00 + 6'(idx_r[2:0] != swr_pkg::CMD_LAST) * (idx_r + 6'h01);
            if (idx_r[2:0] == swr_pkg::CMD_LAST)
            begin
              unique case (cmd_r)
                swr_pkg::CMD_READ: state_r <= swr_pkg::CS_RDID;
                swr_pkg::CMD_MATCH, swr_pkg::CMD_OD_MATCH: state_r <= swr_pkg::CS_WRID;
                swr_pkg::CMD_SEARCH: state_r <= swr_pkg::CS_SRCH;
                default: state_r <= swr_pkg::CS_DONE;
              endcase
            end
          end
        end
        swr_pkg::CS_WRID:
        begin
          if (slot_end)
          begin
            idx_r <= idx_r + 6'h01;
            if (idx_r == swr_pkg::ID_LAST)
              state_r <= swr_pkg::CS_DONE;
          end
        end
        swr_pkg::CS_RDID:
        begin
          if (slot_end)
          begin
            id_r[idx_r] <= rb_r;
            crc_r <= crc_nxt;
            idx_r <= idx_r + 6'h01;
            if (idx_r == swr_pkg::ID_LAST)
            begin
              crc_ok_r <= (crc_nxt == swr_pkg::CRC_INIT);
              state_r <= swr_pkg::CS_DONE;
            end
          end
        end
        swr_pkg::CS_SRCH:
        begin
          if (slot_end)
          begin
            phase_r <= (phase_r == 2'h2) ? 2'h0 : phase_r + 2'h1;
            if (phase_r == 2'h0)
              rd0_r <= rb_r;
            else if (phase_r == 2'h1)
            begin
              // both ones: nobody is left in the search
              if (rd0_r && rb_r)
              begin
                err_r <= 1'b1;
                state_r <= swr_pkg::CS_DONE;
              end
              dir_r <= (rd0_r != rb_r) ? rd0_r : want_r[idx_r];
            end
            else
            begin
              id_r[idx_r] <= dir_r;
              crc_r <= crc_nxt;
              idx_r <= idx_r + 6'h01;
              if (idx_r == swr_pkg::ID_LAST)
              begin
                crc_ok_r <= (crc_nxt == swr_pkg::CRC_INIT);
                state_r <= swr_pkg::CS_DONE;
              end
            end
          end
        end
        swr_pkg::CS_DONE:
        begin
          state_r <= swr_pkg::CS_IDLE;
        end
      endcase
    end
  end
endmodule

// [dv/swr_chk.sv]
// checker on the single-wire line between the controller and peripheral ends
// assumes the swr_if signals plus the bench clock and its synchronous reset
`timescale 1ns/1ns
module swr_chk #(
  parameter logic [15:0] RST_CYC = 16'h00C8,
  parameter logic [15:0] OD_CYC = 16'h003C
)(
  input wire logic clk,
  input wire logic srst,
  input wire logic ctl_o,
  input wire logic ctl_oe_n,
  input wire logic dev_o,
  input wire logic dev_oe_n,
  input wire logic line
);
  logic [15:0] low_r;

  default clocking @(posedge clk);
  endclocking
  default disable iff (srst);

  // length of the current controller pull-down, read at its release
  always_ff @(posedge clk)
  begin
    if (srst || ctl_oe_n)
      low_r <= 16'h0000;
    else
      low_r <= low_r + 16'h0001;
  end

  dev_drv_zero_a: assert property (!dev_oe_n |-> !dev_o)
    else $error("peripheral drives the line high");
  dev_start_a: assert property ($fell(dev_oe_n) |-> !$past(ctl_oe_n) ||
    ($past(ctl_oe_n, 4) && !$past(ctl_oe_n, 5)))
    else $error("peripheral pull outside a slot or presence");
  rst_idle_a: assert property ($fell(srst) |-> ctl_oe_n && dev_oe_n)
    else $error("line not released after reset");
  slot_low_a: assert property ($rose(ctl_oe_n) |-> low_r == 1 || low_r == 6 || low_r >= 16)
    else $error("controller low time fits no slot");
  slot_gap_a: assert property ($rose(ctl_oe_n) && low_r < 16 |-> ctl_oe_n [*5])
    else $error("slot recovery too short");
  rst_len_a: assert property ($rose(ctl_oe_n) && low_r >= 16 |-> low_r == RST_CYC || low_r == OD_CYC)
    else $error("reset pulse length wrong");
  dev_presence_a: assert property ($rose(ctl_oe_n) && low_r >= 16 |-> ##[1:4] !dev_oe_n)
    else $error("no presence after reset");
  dev_quiet_a: assert property (low_r > 16'h0010 |-> dev_oe_n)
    else $error("peripheral pulls during reset");
  dev_pull_a: assert property ($fell(dev_oe_n) |-> !dev_oe_n [*5] ##[1:4] dev_oe_n)
    else $error("peripheral pull length wrong");
endmodule

// [dv/tb_single_wire_rom_function_layer.sv]
// bench joining controller and peripheral ends through one swr_if
// assumes a 100 MHz clock and shortened reset counts on both ends
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
  $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb_single_wire_rom_function_layer;
  localparam logic [7:0] FAM = 8'h2B; // arbitrary value
  localparam logic [47:0] SER = 48'h00A1_B2C3_D4E5; // arbitrary value
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  logic [1:0] req_op = 2'h0;
  logic req_fast_reset = 1'b0;
  logic [7:0] req_cmd = 8'h00;
  logic [63:0] req_id = 64'h0000_0000_0000_0000;
  logic req_ready, rsp_done, rsp_presence, rsp_crc_ok, rsp_err, c_fast;
  logic sel, res_f, d_fast, brst;
  logic [7:0] rom_cmd;
  logic [63:0] rsp_id, id, bad;
  int miscompares = 0;
  int samples_checked = 0;
  int n_brst = 0;
  int seed = 32'h39b6;

  swr_if link();
  swr_ctl #(.RST_LONG_CYC(16'h00C8), .OD_RST_CYC(16'h003C)) swr_ctl_i (.clk(clk), .srst(srst),
    .link(link), .req_valid(req_valid), .req_op(req_op), .req_fast_reset(req_fast_reset),
    .req_cmd(req_cmd), .req_id(req_id), .req_ready(req_ready), .rsp_done(rsp_done),
    .rsp_presence(rsp_presence), .rsp_id(rsp_id), .rsp_crc_ok(rsp_crc_ok),
    .rsp_err(rsp_err), .fast_speed_flag(c_fast));
  swr_dev #(.FAMILY_CODE(FAM), .SERIAL_NUM(SER), .OD_KEEP_CYC(16'h003C)) swr_dev_i (
    .clk(clk), .srst(srst), .link(link), .selected(sel), .rom_cmd(rom_cmd),
    .resume_select_flag(res_f), .fast_speed_flag(d_fast), .bus_reset(brst));
  swr_chk #(.RST_CYC(16'h00C8), .OD_CYC(16'h003C)) swr_chk_i (.clk(clk), .srst(srst),
    .ctl_o(link.ctl_o), .ctl_oe_n(link.ctl_oe_n), .dev_o(link.dev_o),
    .dev_oe_n(link.dev_oe_n), .line(link.line));

  // free-running 100 MHz clock
  always #5 clk = ~clk;

  // count detected bus resets
  always @(posedge clk)
  begin
    if (brst === 1'b1)
      n_brst++;
  end

  // reference identity: crc shifted lsb first from a zero start
  function automatic logic [63:0] mk_id(input logic [55:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++)
    begin
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
    end
    return {c, d};
  endfunction

  // one request; checks happen at a falling edge so outputs have settled
  task automatic op(input logic [1:0] o, input logic f, input logic [7:0] c,
                    input logic [63:0] d);
    int n;
    n = 0;
    @(posedge clk);
    req_valid <= 1'b1;
    {req_op, req_fast_reset, req_cmd, req_id} <= {o, f, c, d};
    @(posedge clk);
    req_valid <= 1'b0;
    while (rsp_done !== 1'b1 && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    if (n >= 4000)
    begin
      miscompares++;
      $display("[ERR] %0t no done", $time);
    end
    @(negedge clk);
  endtask

  task automatic stop_test();
    $display("checked %0d miscompares %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // watchdog: the whole run needs roughly 12.6k cycles, allow about three and a half times that
  initial
  begin
    #450000;
    miscompares++;
    stop_test();
  end

  // main sequence
  initial
  begin
    id = mk_id({SER, FAM});
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    op(2'h0, 1'b0, 8'h00, 64'h0);
    `CHK(rsp_presence, 1'b1)
    `CHK(n_brst, 1)
    `CHK(req_ready, 1'b1)
    op(2'h1, 1'b0, 8'h33, 64'h0);
    `CHK(rsp_id, id)
    `CHK(rsp_crc_ok, 1'b1)
    `CHK(rom_cmd, 8'h33)
    `CHK(res_f, 1'b0)
    op(2'h0, 1'b0, 8'h00, 64'h0);
    op(2'h1, 1'b0, 8'h55, id);
    `CHK(sel, 1'b1)
    `CHK(res_f, 1'b1)
    op(2'h0, 1'b0, 8'h00, 64'h0);
    op(2'h1, 1'b0, 8'hA5, 64'h0);
    `CHK(sel, 1'b1)
    // random single-bit errors anywhere in the identity, crc included
    repeat (3)
    begin
      bad = id ^ (64'h1 << ($random(seed) & 63));
      op(2'h0, 1'b0, 8'h00, 64'h0);
      op(2'h1, 1'b0, 8'h55, bad);
      `CHK(sel, 1'b0)
      `CHK(res_f, 1'b0)
    end
    op(2'h0, 1'b0, 8'h00, 64'h0);
    op(2'h1, 1'b0, 8'hA5, 64'h0);
    `CHK(sel, 1'b0)
    op(2'h0, 1'b0, 8'h00, 64'h0);
    op(2'h1, 1'b0, 8'hCC, 64'h0);
    `CHK(sel, 1'b1)
    op(2'h0, 1'b0, 8'h00, 64'h0);
    op(2'h1, 1'b0, 8'hF0, 64'h0);
    `CHK(rsp_id, id)
    `CHK(rsp_err, 1'b0)
    `CHK(rsp_crc_ok, 1'b1)
    `CHK(res_f, 1'b1)
    op(2'h0, 1'b0, 8'h00, 64'h0);
    op(2'h1, 1'b0, 8'h69, bad);
    `CHK(d_fast, 1'b0)
    `CHK(sel, 1'b0)
    op(2'h0, 1'b0, 8'h00, 64'h0);
    op(2'h1, 1'b0, 8'h69, id);
    `CHK(d_fast, 1'b1)
    `CHK(c_fast, 1'b1)
    `CHK(sel, 1'b1)
    op(2'h0, 1'b1, 8'h00, 64'h0);
    `CHK(d_fast, 1'b1)
    op(2'h1, 1'b0, 8'h3C, 64'h0);
    `CHK(sel, 1'b1)
    op(2'h0, 1'b1, 8'h00, 64'h0);
    op(2'h1, 1'b0, 8'h69, bad);
    `CHK(d_fast, 1'b1)
    op(2'h0, 1'b0, 8'h00, 64'h0);
    `CHK(d_fast, 1'b0)
    `CHK(c_fast, 1'b0)
    stop_test();
  end
endmodule
